// ### hdl/xmd_pkg.sv
package xmd_pkg;

    // first bytes
    localparam logic [7:0] OP_SHORT_PFX  = 8'h3c;
    localparam logic [7:0] OP_SHORT_MID  = 8'h07;
    localparam logic [7:0] OP_SHORT_TAIL = 8'hbd;
    localparam logic [7:0] OP_ABS        = 8'h0a;
    localparam logic [7:0] OP_INDIRECT   = 8'h16;
    localparam logic [7:0] OP_BASED      = 8'h06;
    localparam logic [7:0] OP_REGIDX     = 8'h17;

    // second byte fields: [7] direction, [6:4] code, [3:0] fixed nibble
    localparam int         DIR_BIT        = 7;
    localparam logic [3:0] LOW_NIB        = 4'hd;
    localparam logic [2:0] CODE_ABS16     = 3'h4;
    localparam logic [2:0] CODE_ABS24     = 3'h5;
    localparam logic [2:0] CODE_IMM_MAX   = 3'h3;
    localparam logic [2:0] CODE_BASED_MAX = 3'h4;
    localparam logic [2:0] CODE_REGIDX_MAX = 3'h2;

    // operand byte counts
    localparam logic [1:0] LEN_SHORT = 2'h1;
    localparam logic [1:0] LEN_ABS16 = 2'h2;
    localparam logic [1:0] LEN_ABS24 = 2'h3;
    localparam logic [1:0] LEN_IMM   = 2'h3;
    localparam logic [1:0] LEN_BASED = 2'h1;

    // address byte lanes
    localparam logic [1:0] LANE_LO  = 2'h0;
    localparam logic [1:0] LANE_HI  = 2'h1;
    localparam logic [1:0] LANE_TOP = 2'h2;

    typedef enum logic [2:0] {
        FORM_NONE,
        FORM_SHORT_DIRECT,
        FORM_ABS16,
        FORM_ABS24,
        FORM_INDIRECT,
        FORM_BASED,
        FORM_IMM_INDEXED,
        FORM_REG_INDEXED
    } xmd_form_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PRE1,
        ST_PRE2,
        ST_SECOND,
        ST_OPERAND
    } xmd_state_t;

    // which address lane the n-th operand byte lands in
    function automatic logic [1:0] xmd_lane(input xmd_form_t form, input logic [1:0] idx);
        logic [1:0] lane;
        lane = LANE_LO;
        if (form == FORM_ABS24) begin
            if (idx == 2'h0) lane = LANE_TOP;
            else if (idx == 2'h1) lane = LANE_LO;
            else lane = LANE_HI;
        end else begin
            lane = idx;
        end
        return lane;
    endfunction

endpackage

// ### hdl/xmd_xor_unit.sv
`timescale 1ns/1ps
module xmd_xor_unit #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         go,
    input  wire logic [W-1:0] acc,
    input  wire logic [W-1:0] mem_data,
    input  wire logic         to_mem,
    output logic      [W-1:0] result_q,
    output logic              valid_q,
    output logic              to_mem_q
);
    logic [W-1:0] result_d;
    logic         valid_d;
    logic         to_mem_d;

    always_comb begin
        result_d = result_q;
        to_mem_d = to_mem_q;
        valid_d  = go;
        if (go) begin
            result_d = acc ^ mem_data;
            to_mem_d = to_mem;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_q <= '0;
            valid_q  <= 1'b0;
            to_mem_q <= 1'b0;
        end else begin
            result_q <= result_d;
            valid_q  <= valid_d;
            to_mem_q <= to_mem_d;
        end
    end

    a_xor_value: assert property (@(posedge clk) disable iff (sys_rst)
        go |=> valid_q && result_q == ($past(acc) ^ $past(mem_data))
               && to_mem_q == $past(to_mem))
        else $error("xor result or destination wrong");

endmodule

// ### hdl/xmd_decoder.sv
`timescale 1ns/1ps
module xmd_decoder #(
    parameter int AW = 24
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              byte_valid,
    input  wire logic [7:0]        byte_data,
    output logic                   byte_ready,
    output logic                   dec_valid,
    output logic                   dec_reject,
    output xmd_pkg::xmd_form_t     dec_form,
    output logic [2:0]             dec_sel,
    output logic                   dec_to_mem,
    output logic [AW-1:0]          dec_addr,
    input  wire logic              exec_go,
    input  wire logic [7:0]        exec_acc,
    input  wire logic [7:0]        exec_mem,
    input  wire logic              exec_to_mem,
    output logic [7:0]             xor_result,
    output logic                   xor_valid,
    output logic                   xor_to_mem
);
    import xmd_pkg::*;

    xmd_state_t  state_q,  state_d;
    xmd_form_t   form_q,   form_d;
    logic [7:0]  first_q,  first_d;
    logic [2:0]  sel_q,    sel_d;
    logic        to_mem_q, to_mem_d;
    logic [1:0]  need_q,   need_d;
    logic [1:0]  idx_q,    idx_d;
    logic [23:0] addr_q,   addr_d;
    logic        valid_q,  valid_d;
    logic        reject_q, reject_d;

    logic [2:0]  code;
    logic        dir;
    logic        nib_ok;
    logic [1:0]  lane;

    // never stalls: every byte is consumed the cycle it is offered
    assign byte_ready = 1'b1;
    assign code       = byte_data[6:4];
    assign dir        = byte_data[DIR_BIT];
    assign nib_ok     = byte_data[3:0] == LOW_NIB;
    assign lane       = xmd_lane(form_q, idx_q);

    always_comb begin
        state_d  = state_q;
        form_d   = form_q;
        first_d  = first_q;
        sel_d    = sel_q;
        to_mem_d = to_mem_q;
        need_d   = need_q;
        idx_d    = idx_q;
        addr_d   = addr_q;
        valid_d  = 1'b0;
        reject_d = 1'b0;
        if (byte_valid) begin
            unique case (state_q)
                ST_IDLE: begin
                    first_d = byte_data;
                    addr_d  = '0;
                    idx_d   = 2'h0;
                    if (byte_data == OP_SHORT_PFX) begin
                        state_d = ST_PRE1;
                    end else if (byte_data == OP_ABS || byte_data == OP_INDIRECT ||
                                 byte_data == OP_BASED || byte_data == OP_REGIDX) begin
                        state_d = ST_SECOND;
                    end else begin
                        reject_d = 1'b1;
                    end
                end
                ST_PRE1: begin
                    if (byte_data == OP_SHORT_MID) begin
                        state_d = ST_PRE2;
                    end else begin
                        state_d  = ST_IDLE;
                        reject_d = 1'b1;
                    end
                end
                ST_PRE2: begin
                    if (byte_data == OP_SHORT_TAIL) begin
                        form_d   = FORM_SHORT_DIRECT;
                        to_mem_d = 1'b1;
                        sel_d    = 3'h0;
                        need_d   = LEN_SHORT;
                        state_d  = ST_OPERAND;
                    end else begin
                        state_d  = ST_IDLE;
                        reject_d = 1'b1;
                    end
                end
                ST_SECOND: begin
                    state_d  = ST_IDLE;
                    sel_d    = code;
                    to_mem_d = dir;
                    reject_d = 1'b1;
                    if (nib_ok) begin
                        unique case (first_q)
                            OP_ABS: begin
                                if (code == CODE_ABS16) begin
                                    form_d   = FORM_ABS16;
                                    need_d   = LEN_ABS16;
                                    state_d  = ST_OPERAND;
                                    reject_d = 1'b0;
                                end else if (code == CODE_ABS24) begin
                                    form_d   = FORM_ABS24;
                                    need_d   = LEN_ABS24;
                                    state_d  = ST_OPERAND;
                                    reject_d = 1'b0;
                                end else if (code <= CODE_IMM_MAX) begin
                                    form_d   = FORM_IMM_INDEXED;
                                    need_d   = LEN_IMM;
                                    state_d  = ST_OPERAND;
                                    reject_d = 1'b0;
                                end
                            end
                            OP_INDIRECT: begin
                                form_d   = FORM_INDIRECT;
                                valid_d  = 1'b1;
                                reject_d = 1'b0;
                            end
                            OP_BASED: begin
                                if (code <= CODE_BASED_MAX) begin
                                    form_d   = FORM_BASED;
                                    need_d   = LEN_BASED;
                                    state_d  = ST_OPERAND;
                                    reject_d = 1'b0;
                                end
                            end
                            OP_REGIDX: begin
                                if (code <= CODE_REGIDX_MAX) begin
                                    form_d   = FORM_REG_INDEXED;
                                    valid_d  = 1'b1;
                                    reject_d = 1'b0;
                                end
                            end
                            default: begin
                                reject_d = 1'b1;
                            end
                        endcase
                    end
                end
                ST_OPERAND: begin
                    // lane order differs for the 24-bit absolute form
                    unique case (lane)
                        LANE_LO:  addr_d[7:0]   = byte_data;
                        LANE_HI:  addr_d[15:8]  = byte_data;
                        default:  addr_d[23:16] = byte_data;
                    endcase
                    idx_d  = idx_q + 2'h1;
                    need_d = need_q - 2'h1;
                    if (need_q == 2'h1) begin
                        valid_d = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q  <= ST_IDLE;
            form_q   <= FORM_NONE;
            first_q  <= 8'h00;
            sel_q    <= 3'h0;
            to_mem_q <= 1'b0;
            need_q   <= 2'h0;
            idx_q    <= 2'h0;
            addr_q   <= 24'h000000;
            valid_q  <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            form_q   <= form_d;
            first_q  <= first_d;
            sel_q    <= sel_d;
            to_mem_q <= to_mem_d;
            need_q   <= need_d;
            idx_q    <= idx_d;
            addr_q   <= addr_d;
            valid_q  <= valid_d;
            reject_q <= reject_d;
        end
    end

    assign dec_valid  = valid_q;
    assign dec_reject = reject_q;
    assign dec_form   = form_q;
    assign dec_sel    = sel_q;
    assign dec_to_mem = to_mem_q;
    assign dec_addr   = AW'(addr_q);

    // xor datapath; destination follows the exec_to_mem input, not the decoded direction
    xmd_xor_unit #(
        .W(8)
    ) u_xor (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .go       (exec_go),
        .acc      (exec_acc),
        .mem_data (exec_mem),
        .to_mem   (exec_to_mem),
        .result_q (xor_result),
        .valid_q  (xor_valid),
        .to_mem_q (xor_to_mem)
    );

    a_short_tail: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_PRE2 && byte_valid && byte_data == OP_SHORT_TAIL
        |=> state_q == ST_OPERAND && form_q == FORM_SHORT_DIRECT && to_mem_q
            && need_q == LEN_SHORT)
        else $error("short direct prefix not decoded");

    a_abs16_high: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_OPERAND && form_q == FORM_ABS16 && idx_q == 2'h1 && byte_valid
        |=> dec_valid && dec_addr[15:8] == $past(byte_data))
        else $error("16-bit address high byte misplaced");

    a_abs24_top: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_OPERAND && form_q == FORM_ABS24 && idx_q == 2'h0 && byte_valid
        |=> addr_q[23:16] == $past(byte_data) && !dec_valid)
        else $error("24-bit address top byte misplaced");

    a_abs24_mid: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_OPERAND && form_q == FORM_ABS24 && idx_q == 2'h2 && byte_valid
        |=> dec_valid && dec_addr[15:8] == $past(byte_data))
        else $error("24-bit address middle byte misplaced");

    a_abs_dest: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_SECOND && first_q == OP_ABS && byte_valid && nib_ok
        && (code == CODE_ABS16 || code == CODE_ABS24)
        |=> dec_to_mem == $past(byte_data[DIR_BIT]) && state_q == ST_OPERAND)
        else $error("absolute form direction wrong");

    a_indirect_sel: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_SECOND && first_q == OP_INDIRECT && byte_valid && nib_ok
        |=> dec_valid && dec_form == FORM_INDIRECT && dec_sel == $past(byte_data[6:4])
            && dec_to_mem == $past(byte_data[DIR_BIT]))
        else $error("indirect select wrong");

    a_based_range: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_SECOND && first_q == OP_BASED && byte_valid && nib_ok
        |=> (($past(code) <= CODE_BASED_MAX) ? (state_q == ST_OPERAND && !dec_reject)
                                              : (dec_reject && state_q == ST_IDLE)))
        else $error("based form range wrong");

    a_imm_top: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_OPERAND && form_q == FORM_IMM_INDEXED && idx_q == 2'h2 && byte_valid
        |=> dec_valid && dec_addr[23:16] == $past(byte_data))
        else $error("immediate base top byte misplaced");

    a_regidx_range: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == ST_SECOND && first_q == OP_REGIDX && byte_valid && nib_ok
        |=> (dec_valid == ($past(code) <= CODE_REGIDX_MAX))
            && (dec_reject == ($past(code) > CODE_REGIDX_MAX)))
        else $error("register indexed range wrong");

    // a bad first byte may follow at once, so a reject right after a decode is legal
    a_valid_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        dec_valid |-> !dec_reject ##1 !dec_valid)
        else $error("decode pulse longer than one cycle");

endmodule

// ### tb/xmd_fetch_model.sv
`timescale 1ns/1ps
module xmd_fetch_model (
    input  wire logic       clk,
    output logic            byte_valid,
    output logic      [7:0] byte_data
);

    initial begin
        byte_valid = 1'b0;
        byte_data  = 8'h00;
    end

    // idle cycles show the inverse of the last byte so a stale value never looks valid
    task automatic send(input logic [63:0] seq, input int n, input bit slow);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (slow) begin
                byte_valid <= 1'b0;
                byte_data  <= ~byte_data;
                @(posedge clk);
            end
            byte_valid <= 1'b1;
            byte_data  <= seq[8*(n-1-i) +: 8];
        end
        @(posedge clk);
        byte_valid <= 1'b0;
        byte_data  <= ~byte_data;
    endtask

endmodule

// ### tb/xor_memory_operand_decoder_test.sv
`timescale 1ns/1ps
module xor_memory_operand_decoder_test;
    import xmd_pkg::*;

    typedef struct {
        logic [63:0] seq;
        int          n;
        logic        rej;
        xmd_form_t   form;
        logic [2:0]  sel;
        logic        tm;
        logic [23:0] addr;
    } xmd_row_t;

    logic              clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              byte_valid;
    logic        [7:0] byte_data;
    logic              byte_ready;
    logic              dec_valid;
    logic              dec_reject;
    xmd_form_t         dec_form;
    logic        [2:0] dec_sel;
    logic              dec_to_mem;
    logic       [23:0] dec_addr;
    logic              exec_go = 1'b0;
    logic        [7:0] exec_acc = 8'h00;
    logic        [7:0] exec_mem = 8'h00;
    logic              exec_to_mem = 1'b0;
    logic        [7:0] xor_result;
    logic              xor_valid;
    logic              xor_to_mem;
    int                n_fail = 0;
    int                checks_done = 0;
    int                n_vp = 0;
    int                n_rp = 0;
    xmd_row_t          rows[$];
    logic       [15:0] bad[8] = '{16'h0a6d, 16'h0a7d, 16'h0aed, 16'h0afd,
                                  16'h065d, 16'h173d, 16'h160c, 16'h3c08};

    always #20 clk = ~clk;

    xmd_fetch_model fetch_u (.clk(clk), .byte_valid(byte_valid), .byte_data(byte_data));

    xmd_decoder #(.AW(24)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .byte_valid(byte_valid), .byte_data(byte_data),
        .byte_ready(byte_ready), .dec_valid(dec_valid), .dec_reject(dec_reject),
        .dec_form(dec_form), .dec_sel(dec_sel), .dec_to_mem(dec_to_mem), .dec_addr(dec_addr),
        .exec_go(exec_go), .exec_acc(exec_acc), .exec_mem(exec_mem),
        .exec_to_mem(exec_to_mem), .xor_result(xor_result), .xor_valid(xor_valid),
        .xor_to_mem(xor_to_mem));

    // pulses counted at the edge so back-to-back instructions are not merged
    always @(posedge clk) begin
        if (dec_valid === 1'b1) n_vp++;
        if (dec_reject === 1'b1) n_rp++;
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic add(input logic [63:0] s, input int n, input logic rj, input xmd_form_t f,
                       input logic [2:0] sl, input logic tm, input logic [23:0] a);
        rows.push_back('{s, n, rj, f, sl, tm, a});
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_fail++;
        $display("watchdog expired at %0t", $time);
        close_out();
    end

    initial begin
        logic [7:0] sb;
        int v0;
        int r0;
        add(64'h3c07bd55, 4, 0, FORM_SHORT_DIRECT, 3'h0, 1, 24'h000055);
        add(64'h0a4d3412, 4, 0, FORM_ABS16, 3'h4, 0, 24'h001234);
        add(64'h0a5dab3412, 5, 0, FORM_ABS24, 3'h5, 0, 24'hab1234);
        add(64'h0acd7856, 4, 0, FORM_ABS16, 3'h4, 1, 24'h005678);
        add(64'h0add010203, 5, 0, FORM_ABS24, 3'h5, 1, 24'h010302);
        for (int d = 0; d < 2; d++) begin
            for (int k = 0; k < 8; k++) begin
                sb = {d[0], k[2:0], 4'hd};
                add({8'h16, sb}, 2, 0, FORM_INDIRECT, k[2:0], d[0], 24'h0);
                if (k < 5) add({8'h06, sb, 8'h5a}, 3, 0, FORM_BASED, k[2:0], d[0], 24'h5a);
                if (k < 4) add({8'h0a, sb, 24'h112233}, 5, 0, FORM_IMM_INDEXED, k[2:0], d[0],
                               24'h332211);
                if (k < 3) add({8'h17, sb}, 2, 0, FORM_REG_INDEXED, k[2:0], d[0], 24'h0);
            end
        end
        foreach (bad[i]) add({48'h0, bad[i]}, 2, 1, FORM_NONE, 3'h0, 0, 24'h0);
        add(64'h3c07be, 3, 1, FORM_NONE, 3'h0, 0, 24'h0);
        add(64'hff, 1, 1, FORM_NONE, 3'h0, 0, 24'h0);
        // reset values while reset is held
        repeat (20) @(posedge clk);
        #1;
        chk(24'(byte_ready), 24'h1);
        chk(24'(dec_valid) | 24'(dec_reject) | 24'(xor_valid), 24'h0);
        chk(24'(dec_form), 24'(FORM_NONE));
        chk(dec_addr | 24'(xor_result), 24'h0);
        @(posedge clk);
        sys_rst <= 1'b0;
        $display("test reset done");
        foreach (rows[i]) begin
            fetch_u.send(rows[i].seq, rows[i].n, (i % 3) == 0);
            #1;
            chk(24'(dec_reject), 24'(rows[i].rej));
            chk(24'(dec_valid), 24'(!rows[i].rej));
            if (!rows[i].rej) begin
                chk(24'(dec_form), 24'(rows[i].form));
                chk(24'(dec_sel), 24'(rows[i].sel));
                chk(24'(dec_to_mem), 24'(rows[i].tm));
                chk(dec_addr, rows[i].addr);
            end
        end
        $display("test table done");
        // back to back, with a rejected byte consumed in between
        // let the last table pulse be counted before taking the baseline
        @(posedge clk);
        #1;
        v0 = n_vp;
        r0 = n_rp;
        fetch_u.send(64'h0a4d3412ff168d, 7, 0);
        #1;
        chk(24'(dec_form), 24'(FORM_INDIRECT));
        chk(24'(dec_to_mem), 24'h1);
        @(posedge clk);
        #1;
        chk(24'(n_vp - v0), 24'h2);
        chk(24'(n_rp - r0), 24'h1);
        $display("test back to back done");
        // reset in mid instruction must drop the partial address state
        fetch_u.send(64'h0a4d34, 3, 0);
        sys_rst <= 1'b1;
        @(posedge clk);
        #1;
        chk(24'(dec_form), 24'(FORM_NONE));
        chk(dec_addr, 24'h0);
        @(posedge clk);
        sys_rst <= 1'b0;
        fetch_u.send(64'h160d, 2, 0);
        #1;
        chk(24'(dec_valid), 24'h1);
        chk(24'(dec_form), 24'(FORM_INDIRECT));
        $display("test mid reset done");
        // datapath: both directions, four operand pairs with acc f0, a5, 5a and 0f
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            exec_go     <= 1'b1;
            exec_acc    <= 8'hf0 ^ (8'h55 * k[7:0]);
            exec_mem    <= 8'h3c + (8'h61 * k[7:0]);
            exec_to_mem <= k[0];
            @(posedge clk);
            exec_go <= 1'b0;
            #1;
            chk(24'(xor_valid), 24'h1);
            chk(24'(xor_result), 24'(exec_acc ^ exec_mem));
            chk(24'(xor_to_mem), 24'(k[0]));
        end
        $display("test datapath done");
        close_out();
    end

endmodule
